// ---- include/pwm_ctrl_pkg.sv ----
// Purpose: shared constants and types of the pwm mode/output/irq control
// Assumes: 16-bit peripheral bus, word registers at even byte addresses
// Notes:   addresses are the printed byte addresses
package pwm_ctrl_pkg;

  localparam int NCH = 4;
  localparam int DW  = 16;

  // register byte addresses
  localparam logic [15:0] ADDR_TIMER = 16'hEC00;
  localparam logic [15:0] ADDR_MODE  = 16'hEC02;
  localparam logic [15:0] ADDR_POL   = 16'hEC04;
  localparam logic [15:0] ADDR_TSET  = 16'hEC06;
  localparam logic [15:0] ADDR_TCLR  = 16'hEC08;
  localparam logic [15:0] ADDR_MSET  = 16'hEC0A;
  localparam logic [15:0] ADDR_MCLR  = 16'hEC0C;

  // reset values and implemented-bit masks
  localparam logic [15:0] RST_VAL   = 16'h0000;
  localparam logic [15:0] MODE_MASK = 16'hD0FF;
  localparam logic [15:0] POL_MASK  = 16'h000F;
  localparam logic [15:0] ZERO16    = 16'h0000;

  // timer_irq_ctrl fields
  localparam int RUN_LSB = 0;
  localparam int CKS_LSB = 4;
  localparam int IE_LSB  = 8;
  localparam int IR_LSB  = 12;

  // channel_mode_output_ctrl fields
  localparam int EN_LSB    = 0;
  localparam int ALIGN_LSB = 4;
  localparam int BURST_BIT = 12;
  localparam int SS2_BIT   = 14;
  localparam int SS3_BIT   = 15;

  // one-hot register select
  typedef enum logic [7:0] {
    SEL_NONE  = 8'h01,
    SEL_TIMER = 8'h02,
    SEL_MODE  = 8'h04,
    SEL_POL   = 8'h08,
    SEL_TSET  = 8'h10,
    SEL_TCLR  = 8'h20,
    SEL_MSET  = 8'h40,
    SEL_MCLR  = 8'h80
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(input logic [15:0] addr);
    case (addr)
      ADDR_TIMER: decode_addr = SEL_TIMER;
      ADDR_MODE:  decode_addr = SEL_MODE;
      ADDR_POL:   decode_addr = SEL_POL;
      ADDR_TSET:  decode_addr = SEL_TSET;
      ADDR_TCLR:  decode_addr = SEL_TCLR;
      ADDR_MSET:  decode_addr = SEL_MSET;
      ADDR_MCLR:  decode_addr = SEL_MCLR;
      default:    decode_addr = SEL_NONE;
    endcase
  endfunction : decode_addr

endpackage : pwm_ctrl_pkg

// ---- verif/pwm_ctrl_checker_sva.sv ----
// Purpose: port-level checker of the pwm mode/output/irq control
// Assumes: one clock, asynchronous active-low reset
// Notes:   flags inside the timer register are not visible here
`timescale 1ns/1ns
`default_nettype none
module pwm_ctrl_checker (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // observed ports
  input wire logic       bus_wr,
  input wire logic [3:0] cycle_start,
  input wire logic       irq_source_select_a_en,
  input wire logic       common_irq_enable_a,
  input wire logic       common_irq_clr_a,
  input wire logic       common_irq_flag_a,
  input wire logic       periph_vector_a,
  input wire logic       module_irq,
  input wire logic [3:0] port_output_latch,
  input wire logic [3:0] channel_output_pins,
  input wire logic [3:0] pwm_pin_sel,
  input wire logic [3:0] align_mode_bit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // guarded one edge after reset: pins still hold their reset value there
  property p_pin_latch;
    $past(rst_n) |-> ((~pwm_pin_sel & ~$past(pwm_pin_sel)
      & ~(port_output_latch ^ $past(port_output_latch))
      & (channel_output_pins ^ port_output_latch)) == 4'h0);
  endproperty
  a_pin_latch: assert property (p_pin_latch)
    else $error("disabled pin differs from port latch");

  property p_vec_a;
    periph_vector_a == (common_irq_flag_a & common_irq_enable_a
                        & irq_source_select_a_en);
  endproperty
  a_vec_a: assert property (p_vec_a)
    else $error("vector a does not match flag and enables");

  property p_flag_set;
    $rose(common_irq_flag_a) |->
      ($past(cycle_start) != 4'h0) && $past(irq_source_select_a_en);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("common flag a set without a channel request");

  property p_flag_hold;
    common_irq_flag_a && !common_irq_clr_a |=> common_irq_flag_a;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("common flag a dropped without software clear");

  property p_flag_clr;
    common_irq_clr_a && (cycle_start == 4'h0) |=> !common_irq_flag_a;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("common flag a not cleared");

  property p_irq_rise;
    $rose(module_irq) |-> ($past(cycle_start, 2) != 4'h0) || $past(bus_wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("module irq rose without cause");

  property p_irq_fall;
    $fell(module_irq) |-> $past(bus_wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("module irq fell without a register write");

  property p_sel_src;
    !$stable(pwm_pin_sel) |-> $past(bus_wr) || $past(bus_wr, 2);
  endproperty
  a_sel_src: assert property (p_sel_src)
    else $error("pin select changed without a write");

  property p_align_src;
    !$stable(align_mode_bit) |-> $past(bus_wr) || $past(bus_wr, 2);
  endproperty
  a_align_src: assert property (p_align_src)
    else $error("align mode changed without a write");
endmodule : pwm_ctrl_checker

bind pwm_mode_output_irq_control pwm_ctrl_checker u_chk (
  .mclk                   (mclk),
  .rst_n                  (rst_n),
  .bus_wr                 (bus_wr),
  .cycle_start            (cycle_start),
  .irq_source_select_a_en (irq_source_select_a_en),
  .common_irq_enable_a    (common_irq_enable_a),
  .common_irq_clr_a       (common_irq_clr_a),
  .common_irq_flag_a      (common_irq_flag_a),
  .periph_vector_a        (periph_vector_a),
  .module_irq             (module_irq),
  .port_output_latch      (port_output_latch),
  .channel_output_pins    (channel_output_pins),
  .pwm_pin_sel            (pwm_pin_sel),
  .align_mode_bit         (align_mode_bit)
);
`default_nettype wire

// ---- verif/pwm_mode_output_irq_control_tb_top.sv ----
// Purpose: directed bench for the pwm mode/output/irq control
// Assumes: one-cycle bus strobes, read data one cycle after the strobe
// Notes:   inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ns
`default_nettype none
module pwm_mode_output_irq_control_tb_top;
  logic             mclk, rst_n, bus_wr, bus_rd, pair_burst_bit;
  logic [15:0]      bus_addr, bus_wdata, bus_rdata;
  logic [3:0][15:0] channel_counter, pulse_width_reg;
  logic [3:0]       width_wr, cycle_start, timer_run_bit, clk_div_sel;
  logic [3:0]       align_mode_bit, port_output_latch, port_dir_out;
  logic [3:0]       port_invert_bit, channel_output_pins, pwm_pin_sel;
  logic [1:0]       single_shot_bit;
  logic             common_irq_enable_a, common_irq_enable_b;
  logic             irq_source_select_a_en, irq_source_select_b_en;
  logic             common_irq_clr_a, common_irq_clr_b, pwm_periph_enable;
  logic             common_irq_flag_a, common_irq_flag_b, module_irq;
  logic             periph_vector_a, periph_vector_b;
  int               err_count, comparisons;

  pwm_mode_output_irq_control dut (
    .mclk                   (mclk),
    .rst_n                  (rst_n),
    .bus_addr               (bus_addr),
    .bus_wr                 (bus_wr),
    .bus_rd                 (bus_rd),
    .bus_wdata              (bus_wdata),
    .bus_rdata              (bus_rdata),
    .channel_counter        (channel_counter),
    .pulse_width_reg        (pulse_width_reg),
    .width_wr               (width_wr),
    .cycle_start            (cycle_start),
    .timer_run_bit          (timer_run_bit),
    .clk_div_sel            (clk_div_sel),
    .align_mode_bit         (align_mode_bit),
    .single_shot_bit        (single_shot_bit),
    .pair_burst_bit         (pair_burst_bit),
    .common_irq_enable_a    (common_irq_enable_a),
    .common_irq_enable_b    (common_irq_enable_b),
    .irq_source_select_a_en (irq_source_select_a_en),
    .irq_source_select_b_en (irq_source_select_b_en),
    .common_irq_clr_a       (common_irq_clr_a),
    .common_irq_clr_b       (common_irq_clr_b),
    .common_irq_flag_a      (common_irq_flag_a),
    .common_irq_flag_b      (common_irq_flag_b),
    .periph_vector_a        (periph_vector_a),
    .periph_vector_b        (periph_vector_b),
    .module_irq             (module_irq),
    .port_output_latch      (port_output_latch),
    .port_dir_out           (port_dir_out),
    .pwm_periph_enable      (pwm_periph_enable),
    .port_invert_bit        (port_invert_bit),
    .channel_output_pins    (channel_output_pins),
    .pwm_pin_sel            (pwm_pin_sel)
  );

  always #5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge mclk);
    bus_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge mclk);
    bus_rd   <= 1'b0;
    // read data holds until the next read, so one edge later it is settled
    @(posedge mclk);
    chk("rdata", e, bus_rdata);
  endtask : rd

  task automatic pulse_cs(input logic [3:0] v);
    @(posedge mclk);
    cycle_start <= v;
    @(posedge mclk);
    cycle_start <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask : pulse_cs

  // expected pin built from the xor chain on the current stimulus
  task automatic pin_chk(input logic [3:0] pwm, input logic [3:0] pol);
    repeat (4) @(posedge mclk);
    chk("pins", {12'h000, pwm ^ pol ^ port_invert_bit ^ (port_output_latch
      & port_dir_out & {4{pwm_periph_enable}})}, {12'h000, channel_output_pins});
  endtask : pin_chk

  function automatic logic [15:0] irqv();
    return {11'h000, module_irq, common_irq_flag_a, common_irq_flag_b,
            periph_vector_a, periph_vector_b};
  endfunction : irqv

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("Error watchdog expected done seen hang");
    summarize();
  end

  initial begin
    {mclk, rst_n, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    {channel_counter, pulse_width_reg, width_wr, cycle_start} = '0;
    {port_output_latch, port_dir_out, port_invert_bit} = '0;
    {common_irq_enable_a, common_irq_enable_b, pwm_periph_enable} = '0;
    {irq_source_select_a_en, irq_source_select_b_en} = '0;
    {common_irq_clr_a, common_irq_clr_b, err_count, comparisons} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(pwm_ctrl_pkg::ADDR_MODE, 16'h0000);
    rd(pwm_ctrl_pkg::ADDR_TIMER, 16'h0000);
    wr(pwm_ctrl_pkg::ADDR_MODE, 16'hFFFF);
    rd(pwm_ctrl_pkg::ADDR_MODE, 16'hD0FF);
    chk("modes", {9'h000, pair_burst_bit, single_shot_bit, align_mode_bit},
        16'h007F);
    wr(pwm_ctrl_pkg::ADDR_MCLR, 16'h50F0);
    rd(pwm_ctrl_pkg::ADDR_MODE, 16'h800F);
    chk("modes", {9'h000, pair_burst_bit, single_shot_bit, align_mode_bit},
        16'h0020);
    wr(pwm_ctrl_pkg::ADDR_MSET, 16'h2F30);
    rd(pwm_ctrl_pkg::ADDR_MODE, 16'h803F);
    wr(pwm_ctrl_pkg::ADDR_MCLR, 16'hFFFF);
    rd(pwm_ctrl_pkg::ADDR_MODE, 16'h0000);
    wr(pwm_ctrl_pkg::ADDR_POL, 16'hFFFF);
    rd(pwm_ctrl_pkg::ADDR_POL, 16'h000F);
    rd(pwm_ctrl_pkg::ADDR_MSET, 16'h0000);
    rd(16'hEC0E, 16'h0000);
    $display("test registers done");
    port_output_latch <= 4'b0110;
    port_dir_out      <= 4'b0011;
    repeat (4) @(posedge mclk);
    chk("pins", 16'h0006, {12'h000, channel_output_pins});
    chk("pin_sel", 16'h0000, {12'h000, pwm_pin_sel});
    // ch0 above, ch1 below, ch2 equal, ch3 one below the width
    pulse_width_reg <= {4{16'h0010}};
    channel_counter <= {16'h000F, 16'h0010, 16'h0005, 16'h0020};
    width_wr        <= 4'hF;
    @(posedge mclk);
    width_wr        <= 4'h0;
    wr(pwm_ctrl_pkg::ADDR_MSET, 16'h000F);
    for (int k = 0; k < 8; k++) begin
      wr(pwm_ctrl_pkg::ADDR_POL, {12'h000, {4{k[0]}}});
      port_invert_bit   <= {4{k[1]}};
      pwm_periph_enable <= k[2];
      pin_chk(4'b0101, {4{k[0]}});
    end
    wr(pwm_ctrl_pkg::ADDR_MSET, 16'h1000);
    pin_chk(4'b0100, 4'hF);
    channel_counter[1] <= 16'h0030;
    pin_chk(4'b0111, 4'hF);
    // a width written while running waits for the next cycle start
    wr(pwm_ctrl_pkg::ADDR_TSET, 16'h00FF);
    // the run outputs update on the write edge itself
    @(posedge mclk);
    chk("run", 16'h00FF, {8'h00, clk_div_sel, timer_run_bit});
    pulse_width_reg[2] <= 16'h0040;
    width_wr           <= 4'h4;
    @(posedge mclk);
    width_wr           <= 4'h0;
    pin_chk(4'b0111, 4'hF);
    pulse_cs(4'b0100);
    pin_chk(4'b0011, 4'hF);
    // stop channel 3 first, then force its level through the counter
    wr(pwm_ctrl_pkg::ADDR_TCLR, 16'h0008);
    channel_counter[3] <= 16'h0010;
    pin_chk(4'b1011, 4'hF);
    wr(pwm_ctrl_pkg::ADDR_MCLR, 16'h000F);
    repeat (4) @(posedge mclk);
    chk("pins", 16'h0006, {12'h000, channel_output_pins});
    $display("test pins done");
    wr(pwm_ctrl_pkg::ADDR_TCLR, 16'hFFFF);
    rd(pwm_ctrl_pkg::ADDR_TIMER, 16'h0000);
    common_irq_enable_a    <= 1'b1;
    common_irq_enable_b    <= 1'b1;
    irq_source_select_a_en <= 1'b1;
    irq_source_select_b_en <= 1'b1;
    wr(pwm_ctrl_pkg::ADDR_TSET, 16'h0E00);
    pulse_cs(4'b0001);
    chk("irq", 16'h0000, irqv());
    rd(pwm_ctrl_pkg::ADDR_TIMER, 16'h1E00);
    pulse_cs(4'b0100);
    chk("irq", 16'h001F, irqv());
    rd(pwm_ctrl_pkg::ADDR_TIMER, 16'h5E00);
    common_irq_enable_b <= 1'b0;
    repeat (11) @(posedge mclk);
    chk("irq", 16'h001E, irqv());
    @(posedge mclk);
    common_irq_clr_a <= 1'b1;
    @(posedge mclk);
    common_irq_clr_a <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("irq", 16'h0014, irqv());
    pulse_cs(4'b1000);
    chk("irq", 16'h001E, irqv());
    wr(pwm_ctrl_pkg::ADDR_TCLR, 16'hF000);
    repeat (4) @(posedge mclk);
    chk("irq", 16'h000E, irqv());
    rd(pwm_ctrl_pkg::ADDR_TIMER, 16'h0E00);
    $display("test interrupts done");
    summarize();
  end
endmodule : pwm_mode_output_irq_control_tb_top
`default_nettype wire

// ---- verilog/pwm_mode_output_irq_control.sv ----
// Purpose: mode, output and interrupt control of a four-channel pwm unit
// Assumes: counters, period logic and pads sit outside; bus is synchronous
// Notes:   all register reads and pin values come from flip-flops
`timescale 1ns/1ns
`default_nettype none
module pwm_mode_output_irq_control (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  // peripheral bus
  input  wire logic [15:0]                   bus_addr,
  input  wire logic                          bus_wr,
  input  wire logic                          bus_rd,
  input  wire logic [pwm_ctrl_pkg::DW-1:0]   bus_wdata,
  output logic [pwm_ctrl_pkg::DW-1:0]        bus_rdata,
  // counter side
  input  wire logic [3:0][15:0]              channel_counter,
  input  wire logic [3:0][15:0]              pulse_width_reg,
  input  wire logic [3:0]                    width_wr,
  input  wire logic [3:0]                    cycle_start,
  output logic [3:0]                         timer_run_bit,
  output logic [3:0]                         clk_div_sel,
  output logic [3:0]                         align_mode_bit,
  output logic [1:0]                         single_shot_bit,
  output logic                               pair_burst_bit,
  // interrupt routing
  input  wire logic                          common_irq_enable_a,
  input  wire logic                          common_irq_enable_b,
  input  wire logic                          irq_source_select_a_en,
  input  wire logic                          irq_source_select_b_en,
  input  wire logic                          common_irq_clr_a,
  input  wire logic                          common_irq_clr_b,
  output logic                               common_irq_flag_a,
  output logic                               common_irq_flag_b,
  output logic                               periph_vector_a,
  output logic                               periph_vector_b,
  output logic                               module_irq,
  // port side
  input  wire logic [3:0]                    port_output_latch,
  input  wire logic [3:0]                    port_dir_out,
  input  wire logic                          pwm_periph_enable,
  input  wire logic [3:0]                    port_invert_bit,
  output logic [3:0]                         channel_output_pins,
  output logic [3:0]                         pwm_pin_sel
);

  localparam int NCH = pwm_ctrl_pkg::NCH;

  // registers
  logic [15:0]                 timer_ctrl_r;
  logic [15:0]                 timer_ctrl_nxt;
  logic [15:0]                 mode_ctrl_r;
  logic [15:0]                 mode_ctrl_nxt;
  logic [15:0]                 polarity_r;

  // decoded access
  pwm_ctrl_pkg::reg_sel_t      wr_sel;
  pwm_ctrl_pkg::reg_sel_t      rd_sel;

  // channel views of the registers
  logic [NCH-1:0]              run_bits;
  logic [NCH-1:0]              irq_en_bits;
  logic [NCH-1:0]              irq_flag_bits;
  logic [NCH-1:0]              out_en_bits;

  // pwm path
  logic [NCH-1:0]              pwm_level;
  logic [NCH-1:0]              pwm_merged;
  logic [NCH-1:0]              pin_level;
  logic                        new_chan_req;

  assign wr_sel = bus_wr ? pwm_ctrl_pkg::decode_addr(bus_addr)
                         : pwm_ctrl_pkg::SEL_NONE;
  assign rd_sel = pwm_ctrl_pkg::decode_addr(bus_addr);

  assign run_bits      = timer_ctrl_r[pwm_ctrl_pkg::RUN_LSB +: NCH];
  assign irq_en_bits   = timer_ctrl_r[pwm_ctrl_pkg::IE_LSB +: NCH];
  assign irq_flag_bits = timer_ctrl_r[pwm_ctrl_pkg::IR_LSB +: NCH];
  assign out_en_bits   = mode_ctrl_r[pwm_ctrl_pkg::EN_LSB +: NCH];

  // timer/irq control register: hardware flag set wins over any clear
  always_comb begin
    timer_ctrl_nxt = timer_ctrl_r;
    case (wr_sel)
      pwm_ctrl_pkg::SEL_TIMER: begin
        timer_ctrl_nxt = bus_wdata;
      end
      pwm_ctrl_pkg::SEL_TSET: begin
        timer_ctrl_nxt = timer_ctrl_r | bus_wdata;
      end
      pwm_ctrl_pkg::SEL_TCLR: begin
        timer_ctrl_nxt = timer_ctrl_r & ~bus_wdata;
      end
      default: begin
        timer_ctrl_nxt = timer_ctrl_r;
      end
    endcase
    // flags never clear by hardware, only by the writes above
    timer_ctrl_nxt[pwm_ctrl_pkg::IR_LSB +: NCH] =
      timer_ctrl_nxt[pwm_ctrl_pkg::IR_LSB +: NCH] | cycle_start;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ctrl_r <= pwm_ctrl_pkg::RST_VAL;
    end else begin
      timer_ctrl_r <= timer_ctrl_nxt;
    end
  end

  // mode register with set and clear aliases
  always_comb begin
    mode_ctrl_nxt = mode_ctrl_r;
    case (wr_sel)
      pwm_ctrl_pkg::SEL_MODE: begin
        mode_ctrl_nxt = bus_wdata;
      end
      pwm_ctrl_pkg::SEL_MSET: begin
        mode_ctrl_nxt = mode_ctrl_r | bus_wdata;
      end
      pwm_ctrl_pkg::SEL_MCLR: begin
        mode_ctrl_nxt = mode_ctrl_r & ~bus_wdata;
      end
      default: begin
        mode_ctrl_nxt = mode_ctrl_r;
      end
    endcase
    // holes never store, so they read back zero
    mode_ctrl_nxt = mode_ctrl_nxt & pwm_ctrl_pkg::MODE_MASK;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctrl_r <= pwm_ctrl_pkg::RST_VAL;
    end else begin
      mode_ctrl_r <= mode_ctrl_nxt;
    end
  end

  // polarity register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      polarity_r <= pwm_ctrl_pkg::RST_VAL;
    end else if (wr_sel == pwm_ctrl_pkg::SEL_POL) begin
      polarity_r <= bus_wdata & pwm_ctrl_pkg::POL_MASK;
    end
  end

  // read data: aliases are write only and read as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= pwm_ctrl_pkg::RST_VAL;
    end else if (bus_rd) begin
      case (rd_sel)
        pwm_ctrl_pkg::SEL_TIMER: begin
          bus_rdata <= timer_ctrl_r;
        end
        pwm_ctrl_pkg::SEL_MODE: begin
          bus_rdata <= mode_ctrl_r;
        end
        pwm_ctrl_pkg::SEL_POL: begin
          bus_rdata <= polarity_r;
        end
        default: begin
          bus_rdata <= pwm_ctrl_pkg::ZERO16;
        end
      endcase
    end
  end

  // mode outputs toward the counters
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_run_bit   <= 4'h0;
      clk_div_sel     <= 4'h0;
      align_mode_bit  <= 4'h0;
      single_shot_bit <= 2'h0;
      pair_burst_bit  <= 1'b0;
    end else begin
      timer_run_bit   <= timer_ctrl_nxt[pwm_ctrl_pkg::RUN_LSB +: NCH];
      clk_div_sel     <= timer_ctrl_nxt[pwm_ctrl_pkg::CKS_LSB +: NCH];
      align_mode_bit  <= mode_ctrl_nxt[pwm_ctrl_pkg::ALIGN_LSB +: NCH];
      single_shot_bit <= {mode_ctrl_nxt[pwm_ctrl_pkg::SS3_BIT],
                          mode_ctrl_nxt[pwm_ctrl_pkg::SS2_BIT]};
      pair_burst_bit  <= mode_ctrl_nxt[pwm_ctrl_pkg::BURST_BIT];
    end
  end

  // per-channel shadow and compare
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_cmp
      width_compare u_cmp (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .counter_val (channel_counter[ch]),
        .width_val   (pulse_width_reg[ch]),
        .width_wr    (width_wr[ch]),
        .cycle_start (cycle_start[ch]),
        .timer_run   (run_bits[ch]),
        .pwm_level   (pwm_level[ch])
      );
    end
  endgenerate

  // burst merges channel 1 into channel 0; channel 1 keeps its own pin
  always_comb begin
    pwm_merged = pwm_level;
    if (mode_ctrl_r[pwm_ctrl_pkg::BURST_BIT]) begin
      pwm_merged[0] = pwm_level[0] & pwm_level[1];
    end
  end

  // inversion chain, then pin select
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_pin
      always_comb begin
        // the two inversions cancel when both are set
        pin_level[ch] = pwm_merged[ch] ^ polarity_r[ch]
                        ^ port_invert_bit[ch];
        if (port_dir_out[ch] && pwm_periph_enable) begin
          pin_level[ch] = pin_level[ch] ^ port_output_latch[ch];
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          channel_output_pins[ch] <= 1'b0;
          pwm_pin_sel[ch]         <= 1'b0;
        end else begin
          pwm_pin_sel[ch] <= out_en_bits[ch];
          if (out_en_bits[ch]) begin
            channel_output_pins[ch] <= pin_level[ch];
          end else begin
            channel_output_pins[ch] <= port_output_latch[ch];
          end
        end
      end
    end
  endgenerate

  // a request is new when a cycle start hits an enabled channel
  assign new_chan_req = |(cycle_start & irq_en_bits);

  // common flags: a new request wins over the software clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      common_irq_flag_a <= 1'b0;
    end else if (new_chan_req && irq_source_select_a_en) begin
      common_irq_flag_a <= 1'b1;
    end else if (common_irq_clr_a) begin
      common_irq_flag_a <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      common_irq_flag_b <= 1'b0;
    end else if (new_chan_req && irq_source_select_b_en) begin
      common_irq_flag_b <= 1'b1;
    end else if (common_irq_clr_b) begin
      common_irq_flag_b <= 1'b0;
    end
  end

  // module line is the level of pending enabled channels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      module_irq <= 1'b0;
    end else begin
      module_irq <= |(irq_flag_bits & irq_en_bits);
    end
  end

  // vector requests need the flag and both enables
  assign periph_vector_a = common_irq_flag_a && common_irq_enable_a
                           && irq_source_select_a_en;
  assign periph_vector_b = common_irq_flag_b && common_irq_enable_b
                           && irq_source_select_b_en;

endmodule : pwm_mode_output_irq_control
`default_nettype wire

// ---- verilog/width_compare.sv ----
// Purpose: width shadow latch and counter compare of one channel
// Assumes: width_wr pulses with the new width already on width_val
// Notes:   compare is registered, so the output lags the counter by one clock
`timescale 1ns/1ns
`default_nettype none
module width_compare (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  // counter side
  input  wire logic [pwm_ctrl_pkg::DW-1:0]  counter_val,
  input  wire logic [pwm_ctrl_pkg::DW-1:0]  width_val,
  input  wire logic                         width_wr,
  input  wire logic                         cycle_start,
  input  wire logic                         timer_run,
  // result
  output logic                              pwm_level
);

  logic [pwm_ctrl_pkg::DW-1:0] shadow_r;

  // shadow follows the width at each new cycle, or on a write when stopped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_r <= pwm_ctrl_pkg::RST_VAL;
    end else if (cycle_start || (width_wr && !timer_run)) begin
      shadow_r <= width_val;
    end
  end

  // a stopped counter keeps its value, so the level is held with it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_level <= 1'b0;
    end else begin
      pwm_level <= (counter_val >= shadow_r);
    end
  end

endmodule : width_compare
`default_nettype wire
